// [hw/sensor_i2c_cmd.sv]
// I2C slave command interface of a humidity and temperature sensor
`timescale 1ns/1ns
module sensor_i2c_cmd #(
  parameter logic [31:0] EID_WORD1 = 32'h1122_3344, // Arbitrary value
  parameter logic [31:0] EID_WORD2 = 32'h5566_7788 // Arbitrary value
)(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic address_select_pin,
  input wire logic conv_done,
  input wire logic [15:0] conv_result,
  input wire logic [15:0] conv_temp,
  output logic scl_o,
  output logic scl_oe,
  output logic sda_o,
  output logic sda_oe,
  output logic conv_start,
  output logic [1:0] conv_kind,
  output logic conv_abort,
  output logic [7:0] ureg1,
  output logic [7:0] ureg2,
  output logic [7:0] ureg3
);
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_STRETCH, ST_TX, ST_MACK} state_e;

  // ---------------------------------------------
  // Pin synchronisers and bus events
  // ---------------------------------------------
  logic scl_s1_q, scl_s2_q, scl_p_q, sda_s1_q, sda_s2_q, sda_p_q, sel_s1_q, sel_s2_q;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      {scl_s1_q, scl_s2_q, scl_p_q} <= 3'h7;
      {sda_s1_q, sda_s2_q, sda_p_q} <= 3'h7;
      {sel_s1_q, sel_s2_q} <= 2'h0;
    end
    else
    begin
      {scl_s1_q, scl_s2_q, scl_p_q} <= {scl_i, scl_s1_q, scl_s2_q};
      {sda_s1_q, sda_s2_q, sda_p_q} <= {sda_i, sda_s1_q, sda_s2_q};
      {sel_s1_q, sel_s2_q} <= {address_select_pin, sel_s1_q};
    end
  end

  wire scl_rise = scl_s2_q & ~scl_p_q;
  wire scl_fall = ~scl_s2_q & scl_p_q;
  wire bus_start = scl_s2_q & scl_p_q & sda_p_q & ~sda_s2_q;
  wire bus_stop = scl_s2_q & scl_p_q & ~sda_p_q & sda_s2_q;

  // ---------------------------------------------
  // Byte decode
  // ---------------------------------------------
  state_e st_q;
  logic [7:0] sh_q, cmd_q, arg_q, crc_q;
  logic [3:0] cnt_q;
  logic [1:0] nb_q, kind_q;
  logic [2:0] idx_q, len_q;
  logic first_q, go_tx_q, mack_q, busy_q, hold_q, crc_en_q, zero_q;
  logic [31:0] word_q;
  logic [15:0] last_t_q;
  logic [7:0] coef_q [sensor_pkg::COEF_N];

  wire byte_end = (st_q == ST_RX) & scl_fall & (cnt_q == sensor_pkg::BITS_BYTE);
  wire addr_hit = sh_q[7:1] == {sensor_pkg::ADDR_BASE[6:1], sel_s2_q};
  wire refuse = busy_q & ~hold_q;
  wire rd_ack = byte_end & first_q & addr_hit & sh_q[0] & ~refuse;
  wire wr_evt = byte_end & ~first_q;
  wire cmd_evt = wr_evt & (nb_q == 2'h0);
  wire arg_evt = wr_evt & (nb_q == 2'h1);
  wire dat_evt = wr_evt & (nb_q == 2'h2);
  wire is_rh = (sh_q == sensor_pkg::CMD_RH_HOLD) | (sh_q == sensor_pkg::CMD_RH_POLL);
  wire is_t = (sh_q == sensor_pkg::CMD_T_HOLD) | (sh_q == sensor_pkg::CMD_T_POLL);
  wire is_aux = sh_q == sensor_pkg::CMD_AUX;
  wire start_evt = cmd_evt & (is_rh | is_t | is_aux);
  wire rst_evt = cmd_evt & (sh_q == sensor_pkg::CMD_RESET);
  // aux wait mode from register 2
  wire new_hold = (sh_q == sensor_pkg::CMD_RH_HOLD) | (sh_q == sensor_pkg::CMD_T_HOLD)
    | (is_aux & ~ureg2[sensor_pkg::AUX_POLL_BIT]);
  wire done_evt = conv_done & busy_q;
  wire [1:0] new_kind = is_rh ? sensor_pkg::KIND_RH
    : (is_t ? sensor_pkg::KIND_T : sensor_pkg::KIND_AUX);
  wire [15:0] res_tag = (kind_q == sensor_pkg::KIND_RH)
    ? {conv_result[15:2], sensor_pkg::TAG_RH}
    : ((kind_q == sensor_pkg::KIND_T) ? {conv_result[15:2], sensor_pkg::TAG_T} : conv_result);

  // ---------------------------------------------
  // Coefficient memory
  // ---------------------------------------------
  wire [7:0] coef_ofs = sh_q - sensor_pkg::COEF_FIRST;
  wire [7:0] coef_aofs = arg_q - sensor_pkg::COEF_FIRST;
  wire rd_in = (sh_q >= sensor_pkg::COEF_FIRST) & (sh_q <= sensor_pkg::COEF_LAST);
  wire wr_in = (arg_q >= sensor_pkg::COEF_FIRST) & (arg_q <= sensor_pkg::COEF_LAST);
  wire coef_we = dat_evt & (cmd_q == sensor_pkg::CMD_WR_COEF) & wr_in;
  wire [7:0] coef_rd = rd_in ? coef_q[coef_ofs[5:0]] : sensor_pkg::COEF_BLANK;

  genvar g;
  generate
    for (g = 0; g < sensor_pkg::COEF_N; g++)
    begin : g_coef
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
          coef_q[g] <= sensor_pkg::COEF_BLANK;
        else if (coef_we && coef_aofs == 8'(g))
          coef_q[g] <= sh_q;
      end
    end
  endgenerate

  // ---------------------------------------------
  // Transmit byte selection
  // ---------------------------------------------
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++)
      r = r[7] ? ({r[6:0], 1'b0} ^ sensor_pkg::CRC_POLY) : {r[6:0], 1'b0};
    return r;
  endfunction

  wire crc_slot = crc_en_q & ((idx_q == sensor_pkg::POS_CRC1) | (idx_q == sensor_pkg::POS_CRC2));
  wire [7:0] dat_sel = (idx_q == 3'h0) ? word_q[31:24] : (idx_q == 3'h1) ? word_q[23:16]
    : (idx_q == 3'h3) ? word_q[15:8] : word_q[7:0];
  wire [7:0] tx_byte = (idx_q >= len_q) ? sensor_pkg::IDLE_BYTE : (crc_slot ? crc_q : dat_sel);
  wire stall = busy_q & hold_q;
  // next byte only after master ACK
  wire load = ((st_q == ST_ACK) & scl_fall & go_tx_q & ~stall)
    | ((st_q == ST_STRETCH) & ~busy_q)
    | ((st_q == ST_MACK) & scl_fall & mack_q & (idx_q < len_q));

  // ---------------------------------------------
  // Link state machine
  // ---------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q <= ST_IDLE;
      sh_q <= 8'h00;
      cnt_q <= 4'h0;
      {first_q, go_tx_q, mack_q, sda_oe, scl_oe} <= 5'h00;
      nb_q <= 2'h0;
    end
    else if (bus_start)
    begin
      st_q <= ST_RX;
      {first_q, sda_oe, scl_oe} <= 3'h4;
      cnt_q <= 4'h0;
    end
    else if (bus_stop)
    begin
      st_q <= ST_IDLE;
      {sda_oe, scl_oe} <= 2'h0;
    end
    else if (load)
    begin
      st_q <= ST_TX;
      sh_q <= tx_byte;
      sda_oe <= ~tx_byte[7];
      scl_oe <= 1'b0;
      cnt_q <= 4'h0;
    end
    else
      case (st_q)
        ST_RX:
        begin
          if (scl_rise && cnt_q < sensor_pkg::BITS_BYTE)
          begin
            sh_q <= {sh_q[6:0], sda_s2_q};
            cnt_q <= cnt_q + 4'h1;
          end
          if (byte_end)
          begin
            cnt_q <= 4'h0;
            first_q <= 1'b0;
            go_tx_q <= first_q & sh_q[0];
            nb_q <= first_q ? 2'h0 : (nb_q == 2'h3 ? nb_q : nb_q + 2'h1);
            // foreign address ignored; read refused while a polled (no-hold) conversion is busy
            if (first_q && (!addr_hit || (sh_q[0] && refuse)))
              st_q <= ST_IDLE;
            else
            begin
              st_q <= ST_ACK;
              sda_oe <= 1'b1;
            end
          end
        end
        ST_ACK:
          if (scl_fall)
          begin
            sda_oe <= 1'b0;
            if (go_tx_q)
            begin
              st_q <= ST_STRETCH;
              scl_oe <= 1'b1;
            end
            else
              st_q <= ST_RX;
          end
        ST_STRETCH: scl_oe <= 1'b1;
        ST_TX:
          if (scl_fall)
          begin
            if (cnt_q == sensor_pkg::BIT_LAST)
            begin
              sda_oe <= 1'b0;
              st_q <= ST_MACK;
            end
            else
            begin
              sh_q <= {sh_q[6:0], 1'b0};
              sda_oe <= ~sh_q[6];
              cnt_q <= cnt_q + 4'h1;
            end
          end
        ST_MACK:
        begin
          if (scl_rise)
            mack_q <= ~sda_s2_q;
          // NACK or end of data releases bus
          if (scl_fall)
            st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
  end

  // ---------------------------------------------
  // Read pointer and checksum
  // ---------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      idx_q <= 3'h0;
      crc_q <= sensor_pkg::CRC_INIT;
    end
    else if (rd_ack)
    begin
      idx_q <= 3'h0;
      crc_q <= sensor_pkg::CRC_INIT;
    end
    else if (load)
    begin
      idx_q <= idx_q + 3'h1;
      crc_q <= crc_slot ? sensor_pkg::CRC_INIT : crc8(crc_q, tx_byte);
    end
  end

  // ---------------------------------------------
  // Commands, user registers and conversion
  // ---------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      {cmd_q, arg_q} <= 16'h0000;
      ureg1 <= sensor_pkg::UREG1_RST;
      ureg2 <= sensor_pkg::UREG2_RST;
      ureg3 <= sensor_pkg::UREG3_RST;
      {conv_start, conv_abort, busy_q, hold_q, zero_q} <= 5'h00;
      {conv_kind, kind_q} <= 4'h0;
    end
    else
    begin
      conv_start <= start_evt;
      conv_abort <= rst_evt & busy_q;
      if (cmd_evt)
        cmd_q <= sh_q;
      if (arg_evt)
        arg_q <= sh_q;
      // start conversion and pick wait mode
      if (start_evt)
      begin
        busy_q <= 1'b1;
        hold_q <= new_hold;
        kind_q <= new_kind;
        conv_kind <= new_kind;
      end
      else if (done_evt)
        busy_q <= 1'b0;
      if (rst_evt)
      begin
        busy_q <= 1'b0;
        ureg1 <= sensor_pkg::UREG1_RST;
        ureg2 <= sensor_pkg::UREG2_RST;
        ureg3 <= sensor_pkg::UREG3_RST;
      end
      if (arg_evt && cmd_q == sensor_pkg::CMD_WR_U1)
        ureg1 <= sh_q;
      if (arg_evt && cmd_q == sensor_pkg::CMD_WR_U2)
        ureg2 <= sh_q;
      if (arg_evt && cmd_q == sensor_pkg::CMD_WR_U3)
        ureg3 <= sh_q;
    end
  end

  wire id1 = arg_evt & (cmd_q == sensor_pkg::CMD_ID1) & (sh_q == sensor_pkg::CMD_ID1_ARG);
  wire id2 = arg_evt & (cmd_q == sensor_pkg::CMD_ID2) & (sh_q == sensor_pkg::CMD_ID2_ARG);
  wire rd_u1 = cmd_evt & (sh_q == sensor_pkg::CMD_RD_U1);
  wire rd_u2 = cmd_evt & (sh_q == sensor_pkg::CMD_RD_U2);
  wire rd_u3 = cmd_evt & (sh_q == sensor_pkg::CMD_RD_U3);
  wire rd_cf = arg_evt & (cmd_q == sensor_pkg::CMD_RD_COEF);
  wire [7:0] reg_sel = rd_u1 ? ureg1 : (rd_u2 ? ureg2 : (rd_u3 ? ureg3 : coef_rd));

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      word_q <= 32'h0000_0000;
      last_t_q <= 16'h0000;
      len_q <= 3'h0;
      crc_en_q <= 1'b0;
    end
    // result MS byte first, checksum offered except for aux results
    else if (done_evt)
    begin
      word_q <= {res_tag, 16'h0000};
      len_q <= (kind_q == sensor_pkg::KIND_AUX) ? sensor_pkg::LEN_WORD : sensor_pkg::LEN_MEAS;
      crc_en_q <= kind_q != sensor_pkg::KIND_AUX;
      if (kind_q == sensor_pkg::KIND_RH)
        last_t_q <= conv_temp;
    end
    else if (cmd_evt && sh_q == sensor_pkg::CMD_LAST_T)
    begin
      word_q <= {last_t_q, 16'h0000};
      len_q <= sensor_pkg::LEN_WORD;
      crc_en_q <= 1'b0;
    end
    else if (rd_u1 || rd_u2 || rd_u3 || rd_cf)
    begin
      word_q <= {reg_sel, 24'h00_0000};
      len_q <= sensor_pkg::LEN_REG;
      crc_en_q <= 1'b0;
    end
    else if (id1 || id2)
    begin
      word_q <= id1 ? EID_WORD1 : EID_WORD2;
      len_q <= sensor_pkg::LEN_ID;
      crc_en_q <= 1'b1;
    end
  end

  assign scl_o = zero_q;
  assign sda_o = zero_q;

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  addr_miss_a: assert property (@(posedge clk) disable iff (!arst_n)
    byte_end && first_q && !addr_hit && !bus_start && !bus_stop |=> st_q == ST_IDLE && !sda_oe)
    else $error("foreign address was acknowledged");
  read_refuse_a: assert property (@(posedge clk) disable iff (!arst_n)
    byte_end && first_q && sh_q[0] && refuse && !bus_start && !bus_stop |=> !sda_oe)
    else $error("read address taken while busy");
  stretch_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    st_q == ST_STRETCH && busy_q |=> scl_oe)
    else $error("clock released during conversion");
  crc_seed_a: assert property (@(posedge clk) disable iff (!arst_n)
    rd_ack |=> crc_q == sensor_pkg::CRC_INIT && idx_q == 3'h0)
    else $error("checksum not preset");
  rh_tag_a: assert property (@(posedge clk) disable iff (!arst_n)
    done_evt && kind_q == sensor_pkg::KIND_RH |=> word_q[17:16] == sensor_pkg::TAG_RH)
    else $error("humidity tag wrong");
  t_tag_a: assert property (@(posedge clk) disable iff (!arst_n)
    done_evt && kind_q == sensor_pkg::KIND_T |=> word_q[17:16] == sensor_pkg::TAG_T)
    else $error("temperature tag wrong");
  reg_len_a: assert property (@(posedge clk) disable iff (!arst_n)
    rd_u1 && !done_evt |=> len_q == sensor_pkg::LEN_REG && !crc_en_q)
    else $error("register read carries checksum");
  nack_end_a: assert property (@(posedge clk) disable iff (!arst_n)
    st_q == ST_MACK && scl_fall && !mack_q && !bus_start && !bus_stop |=> st_q == ST_IDLE)
    else $error("byte sent after master NACK");
  reset_cmd_a: assert property (@(posedge clk) disable iff (!arst_n)
    rst_evt |=> !busy_q && ureg1 == sensor_pkg::UREG1_RST)
    else $error("reset command ineffective");
  rh_start_a: assert property (@(posedge clk) disable iff (!arst_n)
    cmd_evt && sh_q == sensor_pkg::CMD_RH_HOLD |=> conv_start && hold_q ##1 !conv_start)
    else $error("humidity start wrong");
endmodule // sensor_i2c_cmd

// [hw/sensor_pkg.sv]
// Constants of the sensor command interface
package sensor_pkg;
  localparam logic [6:0] ADDR_BASE = 7'h40;
  localparam logic [7:0] CMD_RH_HOLD = 8'hE5;
  localparam logic [7:0] CMD_RH_POLL = 8'hF5;
  localparam logic [7:0] CMD_T_HOLD = 8'hE3;
  localparam logic [7:0] CMD_T_POLL = 8'hF3;
  localparam logic [7:0] CMD_AUX = 8'hEE;
  localparam logic [7:0] CMD_LAST_T = 8'hE0;
  localparam logic [7:0] CMD_RESET = 8'hFE;
  localparam logic [7:0] CMD_WR_U2 = 8'h50;
  localparam logic [7:0] CMD_RD_U2 = 8'h10;
  localparam logic [7:0] CMD_WR_U1 = 8'hE6;
  localparam logic [7:0] CMD_RD_U1 = 8'hE7;
  localparam logic [7:0] CMD_WR_U3 = 8'h51;
  localparam logic [7:0] CMD_RD_U3 = 8'h11;
  localparam logic [7:0] CMD_WR_COEF = 8'hC5;
  localparam logic [7:0] CMD_RD_COEF = 8'h84;
  localparam logic [7:0] CMD_ID1 = 8'hFA;
  localparam logic [7:0] CMD_ID1_ARG = 8'h0F;
  localparam logic [7:0] CMD_ID2 = 8'hFC;
  localparam logic [7:0] CMD_ID2_ARG = 8'hC9;
  localparam logic [7:0] CRC_POLY = 8'h31;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [1:0] TAG_RH = 2'h2;
  localparam logic [1:0] TAG_T = 2'h0;
  localparam logic [1:0] KIND_RH = 2'h0;
  localparam logic [1:0] KIND_T = 2'h1;
  localparam logic [1:0] KIND_AUX = 2'h2;
  localparam logic [7:0] UREG1_RST = 8'h3A;
  localparam logic [7:0] UREG2_RST = 8'h00;
  localparam logic [7:0] UREG3_RST = 8'h00;
  localparam int AUX_POLL_BIT = 6;
  localparam logic [7:0] COEF_FIRST = 8'h82;
  localparam logic [7:0] COEF_LAST = 8'hB7;
  localparam int COEF_N = 54;
  localparam logic [7:0] COEF_BLANK = 8'hFF;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [2:0] LEN_REG = 3'h1;
  localparam logic [2:0] LEN_WORD = 3'h2;
  localparam logic [2:0] LEN_MEAS = 3'h3;
  localparam logic [2:0] LEN_ID = 3'h6;
  localparam logic [2:0] POS_CRC1 = 3'h2;
  localparam logic [2:0] POS_CRC2 = 3'h5;
endpackage

// [dv/i2c_host_model.sv]
// I2C master model driving the open-drain bus lines
`timescale 1ns/1ns
module i2c_host_model (
  input wire logic clk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_pull,
  output logic sda_pull,
  output logic timed_out
);
  localparam int HALF = 5;
  initial
  begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    timed_out = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic scl_rise();
    int n;
    n = 0;
    scl_pull <= 1'b0;
    tick(2);
    while (scl !== 1'b1 && n < 20000)
    begin
      tick(1);
      n++;
    end
    if (n >= 20000)
      timed_out <= 1'b1;
    tick(HALF);
  endtask
  // Start or repeated start
  task automatic start_cond();
    sda_pull <= 1'b0;
    tick(HALF);
    scl_rise();
    sda_pull <= 1'b1;
    tick(HALF);
    scl_pull <= 1'b1;
    tick(1);
  endtask
  task automatic stop_cond();
    sda_pull <= 1'b1;
    tick(HALF);
    scl_rise();
    sda_pull <= 1'b0;
    tick(HALF);
  endtask
  // One bit, data changed only while clock low
  task automatic xfer_bit(input logic b, output logic r);
    sda_pull <= ~b;
    tick(HALF);
    scl_rise();
    r = sda;
    scl_pull <= 1'b1;
    tick(1);
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      xfer_bit(b[i], r);
    xfer_bit(1'b1, r);
    ack = ~r;
  endtask
  task automatic get_byte(output logic [7:0] d, input logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      xfer_bit(1'b1, r);
      d[i] = r;
    end
    xfer_bit(~ack, r);
  endtask
endmodule // i2c_host_model

// [dv/humidity_sensor_i2c_cmd_bench.sv]
// Self-checking bench for the sensor command interface
`timescale 1ns/1ns
module humidity_sensor_i2c_cmd_bench;
  typedef logic [7:0] bytes_t[$];
  localparam logic [31:0] ID_A = 32'h9A3C_5E71; // Arbitrary value
  localparam logic [31:0] ID_B = 32'h0F1E_2D3C; // Arbitrary value
  logic clk, arst_n, address_select_pin, conv_done;
  logic [15:0] conv_result, conv_temp, last_t;
  logic scl_o, scl_oe, sda_o, sda_oe, conv_start, conv_abort;
  logic [1:0] conv_kind, kind_seen;
  logic [7:0] ureg1, ureg2, ureg3;
  logic scl_pull, sda_pull, timed_out, scl_w, sda_w;
  logic [6:0] addr;
  int mismatches, checks, conv_wait, cnt, aborts, tries_used;
  assign scl_w = ~(scl_pull | (scl_oe & ~scl_o));
  assign sda_w = ~(sda_pull | (sda_oe & ~sda_o));
  sensor_i2c_cmd #(.EID_WORD1(ID_A), .EID_WORD2(ID_B)) i_sensor_i2c_cmd (
    .clk(clk), .arst_n(arst_n), .scl_i(scl_w), .sda_i(sda_w),
    .address_select_pin(address_select_pin), .conv_done(conv_done),
    .conv_result(conv_result), .conv_temp(conv_temp), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe), .conv_start(conv_start),
    .conv_kind(conv_kind), .conv_abort(conv_abort), .ureg1(ureg1),
    .ureg2(ureg2), .ureg3(ureg3)
  );
  i2c_host_model i_i2c_host_model (
    .clk(clk), .scl(scl_w), .sda(sda_w), .scl_pull(scl_pull),
    .sda_pull(sda_pull), .timed_out(timed_out)
  );
  always #25 clk = ~clk;
  // ------
  // Converter stand-in
  // ------
  always @(posedge clk)
  begin
    conv_done <= (cnt == 1);
    if (conv_start)
    begin
      cnt <= conv_wait;
      kind_seen <= conv_kind;
    end
    else if (cnt > 0)
      cnt <= cnt - 1;
    if (conv_abort)
    begin
      cnt <= 0;
      aborts <= aborts + 1;
    end
  end
  always @(posedge timed_out)
  begin
    mismatches++;
    finish_test();
  end
  // ------
  // Helpers and reference model
  // ------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
    return c;
  endfunction
  function automatic bytes_t id_bytes(input logic [31:0] w);
    return '{w[31:24], w[23:16], crc8(w[31:16]), w[15:8], w[7:0], crc8(w[15:0])};
  endfunction
  task automatic wr(input bytes_t q, input logic p);
    logic a;
    i_i2c_host_model.start_cond();
    i_i2c_host_model.put_byte({addr, 1'b0}, a);
    chk({7'h00, a}, 8'h01);
    foreach (q[i])
    begin
      i_i2c_host_model.put_byte(q[i], a);
      chk({7'h00, a}, 8'h01);
    end
    if (p)
      i_i2c_host_model.stop_cond();
  endtask
  // Retries the read address, reads all bytes, last one refused
  task automatic rd(input bytes_t e, input int tries);
    logic a;
    logic [7:0] d;
    a = 1'b0;
    tries_used = 0;
    while (a !== 1'b1 && tries_used < tries)
    begin
      i_i2c_host_model.start_cond();
      i_i2c_host_model.put_byte({addr, 1'b1}, a);
      tries_used++;
    end
    chk({7'h00, a}, 8'h01);
    if (a !== 1'b1)
      finish_test();
    foreach (e[i])
    begin
      i_i2c_host_model.get_byte(d, i < e.size() - 1);
      chk(d, e[i]);
    end
    // Nothing may follow the refused byte
    i_i2c_host_model.get_byte(d, 1'b0);
    chk(d, 8'hFF);
    tick(4);
    chk({7'h00, sda_oe}, 8'h00);
    i_i2c_host_model.stop_cond();
  endtask
  task automatic meas(input logic [7:0] cmd, input logic [1:0] k, input int w,
    input int t, input logic full);
    logic [15:0] v;
    bytes_t e;
    conv_wait = w;
    conv_result <= 16'($urandom);
    conv_temp <= 16'($urandom) & 16'hFFFC;
    tick(1);
    v = conv_result;
    if (k == 2'h0)
      v[1:0] = 2'b10;
    if (k == 2'h1)
      v[1:0] = 2'b00;
    e = '{v[15:8], v[7:0], (k == 2'h2) ? 8'hFF : crc8(v)};
    if (!full)
      void'(e.pop_back());
    wr('{cmd}, 1'b0);
    rd(e, t);
    chk({6'h00, kind_seen}, {6'h00, k});
    if (k == 2'h0)
      last_t = conv_temp;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ------
  // Main sequence
  // ------
  initial
  begin
    logic a;
    logic [7:0] v;
    logic [7:0] wc[3] = '{8'h50, 8'hE6, 8'h51};
    logic [7:0] rc[3] = '{8'h10, 8'hE7, 8'h11};
    logic [7:0] ca[4] = '{8'h82, 8'h9C, 8'hB6, 8'hB7};
    clk = 1'b0;
    arst_n = 1'b0;
    address_select_pin = 1'b0;
    conv_done = 1'b0;
    conv_result = 16'h0000;
    conv_temp = 16'h0000;
    kind_seen = 2'h3;
    addr = 7'h40;
    {mismatches, checks, conv_wait, cnt, aborts, tries_used} = '0;
    void'($urandom(78));
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    tick(3);
    chk(ureg1, 8'h3A);
    chk(ureg2, 8'h00);
    chk(ureg3, 8'h00);
    for (int p = 0; p < 2; p++)
    begin
      address_select_pin <= p[0];
      addr <= {6'h20, p[0]};
      tick(4);
      i_i2c_host_model.start_cond();
      i_i2c_host_model.put_byte({addr ^ 7'h01, 1'b0}, a);
      chk({7'h00, a}, 8'h00);
      i_i2c_host_model.stop_cond();
      for (int i = 0; i < 3; i++)
      begin
        v = 8'($urandom);
        wr('{wc[i], v}, 1'b1);
        chk((i == 0) ? ureg2 : (i == 1) ? ureg1 : ureg3, v);
        wr('{rc[i]}, 1'b0);
        rd('{v, 8'hFF}, 1);
      end
    end
    $display("test address and registers done");
    wr('{8'h50, 8'h00}, 1'b1);
    meas(8'hE5, 2'h0, 300, 1, 1'b1);
    meas(8'hF5, 2'h0, 600, 20, 1'b1);
    chk(8'(tries_used > 1), 8'h01);
    wr('{8'hE0}, 1'b0);
    rd('{last_t[15:8], last_t[7:0], 8'hFF}, 1);
    meas(8'hE3, 2'h1, 300, 1, 1'b0);
    meas(8'hF3, 2'h1, 600, 20, 1'b1);
    meas(8'hEE, 2'h2, 300, 1, 1'b1);
    wr('{8'h50, 8'h40}, 1'b1);
    meas(8'hEE, 2'h2, 600, 20, 1'b1);
    chk(8'(tries_used > 1), 8'h01);
    wr('{8'h50, 8'h00}, 1'b1);
    $display("test measurements done");
    foreach (ca[i])
    begin
      v = 8'($urandom);
      wr('{8'hC5, ca[i], v}, 1'b1);
      wr('{8'h84, ca[i]}, 1'b0);
      rd('{(ca[i] inside {[8'h82:8'hB7]}) ? v : 8'hFF}, 1);
    end
    wr('{8'h84, 8'h90}, 1'b0);
    rd('{8'hFF}, 1);
    $display("test coefficients done");
    wr('{8'hFA, 8'h0F}, 1'b0);
    rd(id_bytes(ID_A), 1);
    wr('{8'hFC, 8'hC9}, 1'b0);
    rd(id_bytes(ID_B), 1);
    $display("test identifier done");
    wr('{8'hE6, 8'h55}, 1'b1);
    chk(ureg1, 8'h55);
    conv_wait = 3000;
    wr('{8'hF3}, 1'b0);
    wr('{8'hFE}, 1'b1);
    tick(4);
    chk(8'(aborts), 8'h01);
    chk(ureg1, 8'h3A);
    chk(ureg2, 8'h00);
    chk(ureg3, 8'h00);
    meas(8'hE3, 2'h1, 100, 1, 1'b1);
    $display("test reset command done");
    finish_test();
  end
endmodule // humidity_sensor_i2c_cmd_bench
